// ### rtl/mfs_supervisor.sv
// What this block does
// - Deglitched over-threshold current sense raises lock-current event
// - Low two select bits pick power stage state
// - Latched lock-current: hold until clear command
// - Retry lock-current: resume after retry time, clear flags
// - Report-only lock-current: flags only, clear by command
// - Disabled lock-current pattern ignores events
// - Warning sets overtemp and warning flags only
// - Warning on fault pin only when enabled
// - Warning flag clears on command when cool
// - Shutdown: stage off, pump off, flags, pin
// - Shutdown releases on hysteresis; flag needs clear
// - Enabled lock condition raises motor-lock event
// - Pin variant: all detectors, five second retry
// - Latched motor-lock: hold until clear command
// - Retry motor-lock: resume after retry, clear flags
// - Report-only motor-lock: flags only, clear by command
// - Disabled motor-lock pattern ignores events
// - Per-detector enables gate motor-lock contribution
// - Speed above threshold raises abnormal-speed lock
`timescale 1ns/10ps
module mfs_supervisor #(
  parameter int US_CYCLES = mfs_pkg::US_CYCLES,
  parameter int MS_US = mfs_pkg::MS_US
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic pin_config_variant_in,
  input wire logic [11:0] current_sense_amp_in,
  input wire logic [15:0] motor_speed_in,
  input wire logic motor_running_in,
  input wire logic loss_sync_lock_in,
  input wire logic no_motor_lock_in,
  input wire logic temp_warn_in,
  input wire logic temp_warn_hys_in,
  input wire logic temp_sd_in,
  input wire logic temp_sd_hys_in,
  output logic [31:0] reg_rdata_out,
  output logic [2:0] power_stage_out,
  output logic charge_pump_en_out,
  output logic fault_indication_pin_n_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] ilim_mode;
    logic [3:0] lock_mode;
    logic warn_rep;
    logic [2:0] det_en;
    logic [11:0] ilim_thr;
    logic [15:0] speed_thr;
    logic [7:0] deg_us;
    logic [15:0] retry_ms;
    logic [15:0] us_cnt;
    logic [15:0] ms_cnt;
    logic [8:0] deg_cnt;
    logic ilim_over;
    mfs_pkg::mfs_hnd_e [1:0] hst;
    logic [1:0][1:0] hsel;
    logic [1:0][15:0] hretry;
    logic ctrl_fault;
    logic drv_fault;
    logic ilim_flag;
    logic lock_flag;
    logic [2:0] cond_flag;
    logic ot_flag;
    logic tw_flag;
    logic tsd_flag;
    logic tw_pin;
    logic tsd_act;
    logic [31:0] rdata;
    logic [2:0] stage;
    logic cp_en;
    logic fault_n;
  } mfs_state_s;

  mfs_state_s cur_ff;
  mfs_state_s nxt_ff;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Codes outside the four documented groups are treated as disabled
  function automatic mfs_pkg::mfs_cls_e mfs_classify(input logic [3:0] mode);
    if (mode[3:2] == 2'b00) begin
      return mfs_pkg::CLS_LATCH;
    end else if (mode[3:2] == 2'b01) begin
      return mfs_pkg::CLS_RETRY;
    end else if (mode == 4'b1000) begin
      return mfs_pkg::CLS_REPORT;
    end else begin
      return mfs_pkg::CLS_OFF;
    end
  endfunction

  function automatic logic [2:0] mfs_stage(input logic [1:0] sel);
    return 3'({1'b0, sel} + 3'h1);
  endfunction

  // ----------------------------------------------------------------------
  // Combinational view of inputs
  // ----------------------------------------------------------------------
  logic wr_config;
  logic wr_thresh;
  logic wr_timing;
  logic clear_cmd;
  logic us_tick;
  logic ms_tick;
  logic ilim_raw;
  logic [2:0] det_en_eff;
  logic [2:0] lock_hit;
  logic lock_cond;
  logic [3:0] lock_mode_eff;
  logic [15:0] lock_retry_eff;
  logic [1:0] h_cond;
  logic [1:0][3:0] h_mode;
  logic [1:0][15:0] h_retry_lim;

  always_comb begin
    wr_config = reg_wr_in && (reg_addr_in == mfs_pkg::ADDR_CONFIG);
    wr_thresh = reg_wr_in && (reg_addr_in == mfs_pkg::ADDR_THRESH);
    wr_timing = reg_wr_in && (reg_addr_in == mfs_pkg::ADDR_TIMING);
    clear_cmd = reg_wr_in && (reg_addr_in == mfs_pkg::ADDR_CONTROL)
                && reg_wdata_in[mfs_pkg::CTL_CLEAR_BIT];
    us_tick = (cur_ff.us_cnt == 16'(US_CYCLES - 1));
    ms_tick = us_tick && (cur_ff.ms_cnt == 16'(MS_US - 1));
    ilim_raw = current_sense_amp_in > cur_ff.ilim_thr;
    det_en_eff = pin_config_variant_in ? 3'h7 : cur_ff.det_en;
    lock_hit[0] = det_en_eff[0] && (motor_speed_in > cur_ff.speed_thr);
    lock_hit[1] = det_en_eff[1] && loss_sync_lock_in;
    lock_hit[2] = det_en_eff[2] && no_motor_lock_in;
    lock_cond = motor_running_in && (|lock_hit);
    lock_mode_eff = pin_config_variant_in ? mfs_pkg::PIN_LOCK_MODE : cur_ff.lock_mode;
    lock_retry_eff = pin_config_variant_in ? mfs_pkg::PIN_RETRY_MS : cur_ff.retry_ms;
    h_cond[0] = cur_ff.ilim_over;
    h_cond[1] = lock_cond;
    h_mode[0] = cur_ff.ilim_mode;
    h_mode[1] = lock_mode_eff;
    h_retry_lim[0] = cur_ff.retry_ms;
    h_retry_lim[1] = lock_retry_eff;
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [1:0] h_enter;
    logic [1:0] h_leave;
    logic [1:0] h_protect;
    logic [1:0] h_flag;
    logic pin_req;
    mfs_pkg::mfs_cls_e cls;
    h_enter = 2'b00;
    h_leave = 2'b00;
    h_protect = 2'b00;
    h_flag = 2'b00;
    pin_req = 1'b0;
    cls = mfs_pkg::CLS_OFF;
    nxt_ff = cur_ff;

    // Register writes
    if (wr_config) begin
      nxt_ff.ilim_mode = reg_wdata_in[mfs_pkg::CFG_ILIM_MODE_LSB +: 4];
      nxt_ff.lock_mode = reg_wdata_in[mfs_pkg::CFG_LOCK_MODE_LSB +: 4];
      nxt_ff.warn_rep = reg_wdata_in[mfs_pkg::CFG_WARN_REP_BIT];
      nxt_ff.det_en = reg_wdata_in[mfs_pkg::CFG_DET_EN_LSB +: 3];
    end
    if (wr_thresh) begin
      nxt_ff.ilim_thr = reg_wdata_in[mfs_pkg::THR_ILIM_LSB +: 12];
      nxt_ff.speed_thr = reg_wdata_in[mfs_pkg::THR_SPEED_LSB +: 16];
    end
    if (wr_timing) begin
      nxt_ff.deg_us = reg_wdata_in[mfs_pkg::TIM_DEG_LSB +: 8];
      nxt_ff.retry_ms = reg_wdata_in[mfs_pkg::TIM_RETRY_LSB +: 16];
    end

    // Microsecond and millisecond time base
    nxt_ff.us_cnt = us_tick ? 16'h0000 : 16'(cur_ff.us_cnt + 16'h0001);
    if (us_tick) begin
      nxt_ff.ms_cnt = ms_tick ? 16'h0000 : 16'(cur_ff.ms_cnt + 16'h0001);
    end

    // Current deglitch: event only once the level outlasts the filter time
    if (!ilim_raw) begin
      nxt_ff.deg_cnt = 9'h000;
      nxt_ff.ilim_over = 1'b0;
    end else if (us_tick && !cur_ff.ilim_over) begin
      nxt_ff.deg_cnt = 9'(cur_ff.deg_cnt + 9'h001);
      nxt_ff.ilim_over = cur_ff.deg_cnt > {1'b0, cur_ff.deg_us};
    end

    // Response handlers: index 0 lock current, index 1 motor lock
    for (int i = 0; i < 2; i++) begin
      cls = mfs_classify(h_mode[i]);
      case (cur_ff.hst[i])
        mfs_pkg::HND_IDLE: begin
          if (h_cond[i]) begin
            h_enter[i] = 1'b1;
            nxt_ff.hsel[i] = h_mode[i][1:0];
            nxt_ff.hretry[i] = 16'h0000;
            case (cls)
              mfs_pkg::CLS_LATCH: nxt_ff.hst[i] = mfs_pkg::HND_LATCH;
              mfs_pkg::CLS_RETRY: nxt_ff.hst[i] = mfs_pkg::HND_RETRY;
              mfs_pkg::CLS_REPORT: nxt_ff.hst[i] = mfs_pkg::HND_REPORT;
              default: h_enter[i] = 1'b0;
            endcase
          end
        end
        mfs_pkg::HND_LATCH, mfs_pkg::HND_REPORT: begin
          // A condition still present blocks the clear
          if (clear_cmd && !h_cond[i]) begin
            nxt_ff.hst[i] = mfs_pkg::HND_IDLE;
            h_leave[i] = 1'b1;
          end
        end
        mfs_pkg::HND_RETRY: begin
          if (cur_ff.hretry[i] >= h_retry_lim[i]) begin
            nxt_ff.hst[i] = mfs_pkg::HND_IDLE;
            h_leave[i] = 1'b1;
          end else if (ms_tick) begin
            nxt_ff.hretry[i] = 16'(cur_ff.hretry[i] + 16'h0001);
          end
        end
        default: nxt_ff.hst[i] = mfs_pkg::HND_IDLE;
      endcase
      h_protect[i] = (nxt_ff.hst[i] == mfs_pkg::HND_LATCH)
                     || (nxt_ff.hst[i] == mfs_pkg::HND_RETRY);
      h_flag[i] = nxt_ff.hst[i] != mfs_pkg::HND_IDLE;
    end

    // Controller flags follow the handlers
    nxt_ff.ilim_flag = h_flag[0];
    nxt_ff.lock_flag = h_flag[1];
    nxt_ff.ctrl_fault = |h_flag;
    if (h_enter[1]) begin
      nxt_ff.cond_flag = cur_ff.cond_flag | lock_hit;
    end else if (h_leave[1]) begin
      nxt_ff.cond_flag = 3'h0;
    end else if (h_flag[1]) begin
      nxt_ff.cond_flag = cur_ff.cond_flag | lock_hit;
    end

    // Thermal warning; set wins over clear
    if (clear_cmd && !temp_warn_in) begin
      nxt_ff.tw_flag = 1'b0;
    end
    if (temp_warn_in) begin
      nxt_ff.tw_flag = 1'b1;
      nxt_ff.tw_pin = 1'b1;
    end else if (!temp_warn_hys_in) begin
      nxt_ff.tw_pin = 1'b0;
    end

    // Thermal shutdown; cannot be disabled
    if (temp_sd_in) begin
      nxt_ff.tsd_act = 1'b1;
    end else if (!temp_sd_hys_in) begin
      nxt_ff.tsd_act = 1'b0;
    end
    if (clear_cmd) begin
      nxt_ff.tsd_flag = 1'b0;
      nxt_ff.drv_fault = 1'b0;
    end
    if (temp_sd_in) begin
      nxt_ff.tsd_flag = 1'b1;
      nxt_ff.drv_fault = 1'b1;
    end
    if (clear_cmd && !temp_warn_in && !temp_sd_in) begin
      nxt_ff.ot_flag = 1'b0;
    end
    if (temp_warn_in || temp_sd_in) begin
      nxt_ff.ot_flag = 1'b1;
    end

    // Power stage: shutdown first, then lock current, then motor lock
    if (nxt_ff.tsd_act) begin
      nxt_ff.stage = mfs_pkg::STG_ALL_OFF;
    end else if (h_protect[0]) begin
      nxt_ff.stage = mfs_stage(nxt_ff.hsel[0]);
    end else if (h_protect[1]) begin
      nxt_ff.stage = mfs_stage(nxt_ff.hsel[1]);
    end else begin
      nxt_ff.stage = mfs_pkg::STG_NORMAL;
    end
    nxt_ff.cp_en = !nxt_ff.tsd_act;

    // Fault pin: OR of every source asking for indication
    pin_req = nxt_ff.tsd_act || (|h_protect)
              || (nxt_ff.tw_pin && cur_ff.warn_rep);
    nxt_ff.fault_n = !pin_req;

    // Read data stands only in the cycle after the strobe
    nxt_ff.rdata = 32'h0000_0000;
    if (reg_rd_in) begin
      case (reg_addr_in)
        mfs_pkg::ADDR_CONFIG: begin
          nxt_ff.rdata[mfs_pkg::CFG_ILIM_MODE_LSB +: 4] = cur_ff.ilim_mode;
          nxt_ff.rdata[mfs_pkg::CFG_LOCK_MODE_LSB +: 4] = cur_ff.lock_mode;
          nxt_ff.rdata[mfs_pkg::CFG_WARN_REP_BIT] = cur_ff.warn_rep;
          nxt_ff.rdata[mfs_pkg::CFG_DET_EN_LSB +: 3] = cur_ff.det_en;
        end
        mfs_pkg::ADDR_THRESH: begin
          nxt_ff.rdata[mfs_pkg::THR_ILIM_LSB +: 12] = cur_ff.ilim_thr;
          nxt_ff.rdata[mfs_pkg::THR_SPEED_LSB +: 16] = cur_ff.speed_thr;
        end
        mfs_pkg::ADDR_TIMING: begin
          nxt_ff.rdata[mfs_pkg::TIM_DEG_LSB +: 8] = cur_ff.deg_us;
          nxt_ff.rdata[mfs_pkg::TIM_RETRY_LSB +: 16] = cur_ff.retry_ms;
        end
        mfs_pkg::ADDR_STATUS: begin
          nxt_ff.rdata[15:0] = {cur_ff.hst[1], cur_ff.hst[0], cur_ff.tsd_act,
                                cur_ff.tw_flag, cur_ff.tsd_flag, cur_ff.ot_flag,
                                cur_ff.cond_flag, cur_ff.lock_flag, cur_ff.ilim_flag,
                                cur_ff.drv_fault, cur_ff.ctrl_fault};
        end
        default: nxt_ff.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cur_ff <= '0;
      cur_ff.ilim_mode <= mfs_pkg::RST_ILIM_MODE;
      cur_ff.lock_mode <= mfs_pkg::RST_LOCK_MODE;
      cur_ff.det_en <= mfs_pkg::RST_DET_EN;
      cur_ff.ilim_thr <= mfs_pkg::RST_ILIM_THR;
      cur_ff.speed_thr <= mfs_pkg::RST_SPEED_THR;
      cur_ff.deg_us <= mfs_pkg::RST_DEG_US;
      cur_ff.retry_ms <= mfs_pkg::RST_RETRY_MS;
      cur_ff.stage <= mfs_pkg::STG_NORMAL;
      cur_ff.cp_en <= 1'b1;
      cur_ff.fault_n <= 1'b1;
    end else if (clk_en_in) begin
      cur_ff <= nxt_ff;
    end
  end

  always_comb begin
    reg_rdata_out = cur_ff.rdata;
    power_stage_out = cur_ff.stage;
    charge_pump_en_out = cur_ff.cp_en;
    fault_indication_pin_n_out = cur_ff.fault_n;
  end

endmodule // mfs_supervisor

// ### rtl/mfs_pkg.sv
package mfs_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_THRESH = 8'h04;
  localparam logic [7:0] ADDR_TIMING = 8'h08;
  localparam logic [7:0] ADDR_CONTROL = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CFG_ILIM_MODE_LSB = 0;
  localparam int CFG_LOCK_MODE_LSB = 4;
  localparam int CFG_WARN_REP_BIT = 8;
  localparam int CFG_DET_EN_LSB = 9;
  localparam int THR_ILIM_LSB = 0;
  localparam int THR_SPEED_LSB = 16;
  localparam int TIM_DEG_LSB = 0;
  localparam int TIM_RETRY_LSB = 16;
  localparam int CTL_CLEAR_BIT = 0;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0] RST_ILIM_MODE = 4'h0;
  localparam logic [3:0] RST_LOCK_MODE = 4'h0;
  localparam logic [2:0] RST_DET_EN = 3'h7;
  localparam logic [11:0] RST_ILIM_THR = 12'hFFF;
  localparam logic [15:0] RST_SPEED_THR = 16'hFFFF;
  localparam logic [7:0] RST_DEG_US = 8'h0A;
  localparam logic [15:0] RST_RETRY_MS = 16'h01F4;

  // Fixed behaviour of the pin-configured variant
  localparam logic [3:0] PIN_LOCK_MODE = 4'h4;
  localparam logic [15:0] PIN_RETRY_MS = 16'h1388;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam int MS_US = 1000;

  // ----------------------------------------------------------------------
  // Power stage codes and types
  // ----------------------------------------------------------------------
  localparam logic [2:0] STG_NORMAL = 3'h0;
  localparam logic [2:0] STG_ALL_OFF = 3'h1;

  typedef enum logic [1:0] {HND_IDLE, HND_LATCH, HND_RETRY, HND_REPORT} mfs_hnd_e;
  typedef enum logic [1:0] {CLS_LATCH, CLS_RETRY, CLS_REPORT, CLS_OFF} mfs_cls_e;

endpackage

// ### dv/mfs_assertions.sv
`timescale 1ns/10ps
module mfs_assertions (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic reg_rd_in,
  input wire logic temp_sd_in,
  input wire logic temp_sd_hys_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic [2:0] power_stage_out,
  input wire logic charge_pump_en_out,
  input wire logic fault_indication_pin_n_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // --------------------
  // Thermal shutdown
  // --------------------
  a_sd_stage: assert property (clk_en_in && temp_sd_in |=> power_stage_out == 3'h1)
    else $error("shutdown left the stage on");
  a_sd_pump: assert property (clk_en_in && temp_sd_in |=> !charge_pump_en_out && !fault_indication_pin_n_out)
    else $error("shutdown left pump or pin on");
  a_sd_hold: assert property (clk_en_in && temp_sd_hys_in && !charge_pump_en_out |=> !charge_pump_en_out)
    else $error("shutdown ended inside hysteresis");
  a_sd_release: assert property (clk_en_in && !temp_sd_in && !temp_sd_hys_in |=> charge_pump_en_out)
    else $error("pump not back after cooling");
  // Pump may only drop with a hot die one edge before
  a_pump_cause: assert property (!charge_pump_en_out && $past(clk_en_in) |-> $past(temp_sd_in) || $past(temp_sd_hys_in))
    else $error("pump off without heat");
  // --------------------
  // Stage, pin and bus
  // --------------------
  a_stage_pin: assert property (power_stage_out != 3'h0 |-> !fault_indication_pin_n_out)
    else $error("protective stage without fault pin");
  a_stage_code: assert property (power_stage_out <= 3'h4)
    else $error("stage code out of range");
  a_rd_idle: assert property ($past(clk_en_in) && !$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000)
    else $error("read data outside read slot");
  c_shutdown: cover property (!charge_pump_en_out);
  c_low_side: cover property (power_stage_out == 3'h4);
  c_read: cover property (reg_rdata_out != 32'h0000_0000);
endmodule // mfs_assertions

bind mfs_supervisor mfs_assertions u_chk (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in), .reg_rd_in(reg_rd_in),
  .temp_sd_in(temp_sd_in), .temp_sd_hys_in(temp_sd_hys_in), .reg_rdata_out(reg_rdata_out),
  .power_stage_out(power_stage_out), .charge_pump_en_out(charge_pump_en_out),
  .fault_indication_pin_n_out(fault_indication_pin_n_out));

// ### dv/mfs_motor_model.sv
`timescale 1ns/10ps
module mfs_motor_model (
  input wire logic core_clk_in,
  input wire logic stall_in,
  input wire logic overspeed_in,
  input wire logic [2:0] power_stage_in,
  input wire logic charge_pump_en_in,
  output logic motor_running_out,
  output logic [11:0] current_sense_amp_out,
  output logic [15:0] motor_speed_out
);
  // --------------------
  // Motor seen through the stage
  // --------------------
  // Only a normally driven motor draws stall current or spins, so a cut stage clears the cause
  logic driven;
  assign driven = charge_pump_en_in && power_stage_in == 3'h0;
  initial motor_running_out = 1'b0;
  initial current_sense_amp_out = 12'h040;
  initial motor_speed_out = 16'h0000;
  always @(posedge core_clk_in) begin
    motor_running_out <= driven;
    current_sense_amp_out <= (driven && stall_in) ? 12'h800 : 12'h040;
    motor_speed_out <= !driven ? 16'h0000 : (overspeed_in ? 16'h4000 : 16'h1000);
  end
endmodule // mfs_motor_model

// ### dv/test_motor_fault_supervisor.sv
`timescale 1ns/10ps
`define CHK(nm, ex, sn) begin check_count++; if ((sn) !== (ex)) begin failures++; $display("[FAIL] %s exp %0h got %0h", nm, ex, sn); end end
module test_motor_fault_supervisor;
  // --------------------
  // Signals
  // --------------------
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic pin_var = 1'b0;
  logic stall = 1'b0;
  logic over = 1'b0;
  logic loss_sync = 1'b0;
  logic no_motor = 1'b0;
  logic [3:0] temp = 4'h0;
  logic running;
  logic [11:0] current_sense_amp;
  logic [15:0] speed;
  logic [31:0] rdata;
  logic [2:0] stage;
  logic pump;
  logic pin_n;
  logic [31:0] rv;
  int failures = 0;
  int check_count = 0;
  int seed = 32'h4ddb;
  int n;
  int mode;
  int src;
  int q[$] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 11, 13, 15, 16, 21, 24, 25};

  mfs_supervisor #(.US_CYCLES(4), .MS_US(4)) u_dut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_en), .reg_rd_in(rd_en),
    .pin_config_variant_in(pin_var), .current_sense_amp_in(current_sense_amp), .motor_speed_in(speed),
    .motor_running_in(running), .loss_sync_lock_in(loss_sync), .no_motor_lock_in(no_motor),
    .temp_warn_in(temp[0]), .temp_warn_hys_in(temp[1]), .temp_sd_in(temp[2]),
    .temp_sd_hys_in(temp[3]), .reg_rdata_out(rdata), .power_stage_out(stage),
    .charge_pump_en_out(pump), .fault_indication_pin_n_out(pin_n));
  mfs_motor_model u_motor (
    .core_clk_in(core_clk_in), .stall_in(stall), .overspeed_in(over),
    .power_stage_in(stage), .charge_pump_en_in(pump), .motor_running_out(running),
    .current_sense_amp_out(current_sense_amp), .motor_speed_out(speed));

  // --------------------
  // Bus and helper tasks
  // --------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk_in);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_in);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk_in);
    rd_en <= 1'b0;
    // Read data stands only in the cycle right after the strobe edge
    #1 rv = rdata;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk_in);
    #1;
  endtask
  // Waits until the stage moves, n holds the cycles spent
  task automatic wchg(input int mx);
    logic [2:0] s0;
    #1 s0 = stage;
    n = 0;
    while (stage === s0 && n < mx) begin
      @(posedge core_clk_in);
      #1 n++;
    end
  endtask
  task automatic results();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    forever #5 core_clk_in = ~core_clk_in;
  end
  // Whole run is about a thousand cycles
  initial begin
    #300000;
    failures++;
    results();
  end

  // --------------------
  // Scenarios
  // --------------------
  initial begin
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rd(mfs_pkg::ADDR_CONFIG);
    `CHK("config", {20'h0_0000, mfs_pkg::RST_DET_EN, 1'b0, 8'h00}, rv)
    rd(mfs_pkg::ADDR_STATUS);
    `CHK("status", 32'h0000_0000, rv)
    rd(8'h14);
    `CHK("unmapped", 32'h0000_0000, rv)
    src = $random(seed);
    wr(mfs_pkg::ADDR_THRESH, src & 32'hFFFF_0FFF);
    @(posedge core_clk_in);
    clk_en_in <= 1'b0;
    wr(mfs_pkg::ADDR_THRESH, 32'h0000_0000);
    @(posedge core_clk_in);
    clk_en_in <= 1'b1;
    rd(mfs_pkg::ADDR_THRESH);
    `CHK("thresh", src & 32'hFFFF_0FFF, rv)
    wr(mfs_pkg::ADDR_THRESH, 32'h2000_0100);
    wr(mfs_pkg::ADDR_TIMING, 32'h0003_0002);
    // Both response selects walked; the other handler is kept disabled
    foreach (q[i]) begin
      mode = q[i] % 16;
      src = q[i] / 16;
      wr(mfs_pkg::ADDR_CONFIG, src ? (32'h0000_0E09 | mode << 4) : (32'h0000_0E90 | mode));
      @(posedge core_clk_in);
      stall <= (src == 0);
      over <= (src == 1);
      wchg(40);
      if (src == 0 && mode < 8) `CHK("deglitch", 1'b1, n > 8 && n <= 24)
      @(posedge core_clk_in);
      stall <= 1'b0;
      over <= 1'b0;
      #1 `CHK("stage", mode < 8 ? 3'((mode % 4) + 1) : 3'h0, stage)
      if (mode < 8) `CHK("pin", 1'b0, pin_n)
      rd(mfs_pkg::ADDR_STATUS);
      `CHK("flag", (mode & 9) != 9, rv[2 + src])
      if (mode >= 4 && mode < 8) begin
        wchg(70);
        `CHK("retry", 1'b1, n >= 26 && n <= 52)
        rd(mfs_pkg::ADDR_STATUS);
        `CHK("retry flags", 2'b00, {rv[2 + src], rv[0]})
      end else begin
        `CHK("still", mode < 8 ? 3'((mode % 4) + 1) : 3'h0, stage)
        wr(mfs_pkg::ADDR_CONTROL, 32'h0000_0001);
        rd(mfs_pkg::ADDR_STATUS);
        `CHK("cleared", 1'b0, rv[2 + src])
      end
      `CHK("resumed", 3'h0, stage)
    end
    for (int d = 0; d < 3; d++) begin
      for (int e = 0; e < 2; e++) begin
        rv = e ? 32'h0000_0E00 : 32'h0000_0E00 & ~(32'h0000_0200 << d);
        wr(mfs_pkg::ADDR_CONFIG, rv | 32'h0000_0009);
        @(posedge core_clk_in);
        over <= (d == 0);
        loss_sync <= (d == 1);
        no_motor <= (d == 2);
        wchg(20);
        `CHK("lock stage", e ? 3'h1 : 3'h0, stage)
        @(posedge core_clk_in);
        {over, loss_sync, no_motor} <= 3'h0;
        rd(mfs_pkg::ADDR_STATUS);
        `CHK("lock flags", e ? 3'h7 : 3'h0, {rv[3], rv[4 + d], rv[0]})
        wr(mfs_pkg::ADDR_CONTROL, 32'h0000_0001);
        tick(3);
        `CHK("lock resume", 3'h0, stage)
      end
    end
    wr(mfs_pkg::ADDR_CONFIG, 32'h0000_0E99);
    @(posedge core_clk_in);
    temp <= 4'h3;
    tick(3);
    `CHK("warn pin off", 1'b1, pin_n)
    `CHK("warn stage", 3'h0, stage)
    wr(mfs_pkg::ADDR_CONTROL, 32'h0000_0001);
    rd(mfs_pkg::ADDR_STATUS);
    `CHK("warn flags", 2'b11, {rv[9], rv[7]})
    wr(mfs_pkg::ADDR_CONFIG, 32'h0000_0F99);
    tick(2);
    `CHK("warn pin on", 1'b0, pin_n)
    @(posedge core_clk_in);
    temp <= 4'h2;
    tick(3);
    `CHK("warn hyst", 1'b0, pin_n)
    @(posedge core_clk_in);
    temp <= 4'h0;
    tick(3);
    `CHK("warn release", 1'b1, pin_n)
    wr(mfs_pkg::ADDR_CONTROL, 32'h0000_0001);
    rd(mfs_pkg::ADDR_STATUS);
    `CHK("warn cleared", 1'b0, rv[9])
    @(posedge core_clk_in);
    temp <= 4'hF;
    tick(2);
    `CHK("sd", 5'h04, {stage, pump, pin_n})
    rd(mfs_pkg::ADDR_STATUS);
    `CHK("sd flags", 3'h7, {rv[8], rv[7], rv[1]})
    @(posedge core_clk_in);
    temp <= 4'hB;
    tick(3);
    `CHK("sd hyst", 1'b0, pump)
    @(posedge core_clk_in);
    temp <= 4'h0;
    tick(3);
    `CHK("sd exit", 5'h03, {stage, pump, pin_n})
    rd(mfs_pkg::ADDR_STATUS);
    `CHK("sd latched", 1'b1, rv[8])
    wr(mfs_pkg::ADDR_CONTROL, 32'h0000_0001);
    rd(mfs_pkg::ADDR_STATUS);
    `CHK("sd cleared", 1'b0, rv[8])
    // Variant forces retry even with the select disabled; five seconds is not waited out
    @(posedge core_clk_in);
    pin_var <= 1'b1;
    over <= 1'b1;
    wchg(20);
    `CHK("variant", mfs_pkg::STG_ALL_OFF, stage)
    rd(mfs_pkg::ADDR_STATUS);
    `CHK("variant mode", mfs_pkg::HND_RETRY, rv[14:13])
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    over <= 1'b0;
    pin_var <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    tick(1);
    `CHK("rst outputs", 5'h03, {stage, pump, pin_n})
    results();
  end
endmodule // test_motor_fault_supervisor
